// ### rtl/gcd_pkg.sv
// Package: opcodes, latencies, operand and result carriers for the guarded datapath
package gcd_pkg;
    localparam logic [7:0] GCD_OP_CMP_REG   = 8'h25;  // Register equality compare, code 37
    localparam logic [7:0] GCD_OP_CMP_IMM   = 8'h04;  // Immediate equality compare, code 4
    localparam logic [7:0] GCD_OP_DOT_MIXED = 8'h5B;  // Mixed byte dot product, code 91
    localparam logic [7:0] GCD_OP_DOT_BYTE  = 8'h5C;  // Signed byte dot product, code 92
    localparam logic [7:0] GCD_OP_DOT_HALF  = 8'h5D;  // Halfword dot product, code 93
    localparam int         GCD_ALU_LAT      = 1;      // Compare latency in cycles
    localparam int         GCD_DSP_LAT      = 3;      // Dot product latency in cycles
    localparam int         GCD_IMM_W        = 7;      // Immediate modifier width
    localparam logic [31:0] GCD_SAT_MAX     = 32'h7FFFFFFF;  // Upper clip bound
    localparam logic [31:0] GCD_SAT_MIN     = 32'h80000000;  // Lower clip bound
    localparam logic [31:0] GCD_ZERO        = 32'h00000000;  // Reset value of data
    localparam logic [4:0]  GCD_DEST_ZERO   = 5'h00;         // Reset value of destination tag

    // Issued operation
    typedef struct packed {
        logic        valid;       // Operation present this cycle
        logic [7:0]  opcode;      // Operation code
        logic [31:0] firstSource; // First source operand
        logic [31:0] secondSource;// Second source operand
        logic [6:0]  modifier;    // Signed immediate modifier
        logic        guardUsed;   // Guard operand supplied
        logic [31:0] guard;       // Guard register value
        logic [4:0]  dest;        // Destination register index
    } gcd_issue_t;

    // Writeback request
    typedef struct packed {
        logic        write;       // Write destination this cycle
        logic [4:0]  dest;        // Destination register index
        logic [31:0] data;        // Result value
    } gcd_wb_t;
endpackage

// ### rtl/gcd_dot_pipe.sv
// Three-stage dot product pipeline for halfword and byte operations
`timescale 1ns/10ps
module gcd_dot_pipe (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            startValid,
    input  wire logic [7:0]      startOp,
    input  wire logic [31:0]     startA,
    input  wire logic [31:0]     startB,
    input  wire logic            startWrite,
    input  wire logic [4:0]      startDest,
    output gcd_pkg::gcd_wb_t     dotWb
);
    import gcd_pkg::*;

    // Pipeline state: stage one holds products, stage two the sum
    typedef struct packed {
        logic               v1;
        logic               w1;
        logic [4:0]         d1;
        logic [7:0]         op1;
        logic signed [33:0] p0;
        logic signed [33:0] p1;
        logic signed [33:0] p2;
        logic signed [33:0] p3;
        logic               v2;
        logic               w2;
        logic [4:0]         d2;
        logic [31:0]        r2;
        gcd_wb_t            out;
    } gcd_dot_state_t;

    gcd_dot_state_t state_reg;  // Registered pipeline
    gcd_dot_state_t state_next; // Next pipeline value

    // Byte lane product, first operand optionally unsigned
    function automatic logic signed [33:0] lane_mul(input logic [7:0] a, input logic [7:0] b, input logic uns);
        logic signed [8:0] ax;
        logic signed [8:0] bx;
        ax = uns ? $signed({1'b0, a}) : $signed({a[7], a});
        bx = $signed({b[7], b});
        lane_mul = 34'(ax * bx);
    endfunction

    // Stage logic
    always_comb begin
        logic signed [34:0] sum;
        logic               uns;
        sum = '0;
        uns = 1'b0;
        state_next = state_reg;
        // Stage one: exact products
        state_next.v1  = startValid;
        state_next.w1  = startWrite;
        state_next.d1  = startDest;
        state_next.op1 = startOp;
        if (startOp == GCD_OP_DOT_HALF) begin
            // Sign-extended halfword products, full precision
            state_next.p0 = 34'($signed(startA[31:16]) * $signed(startB[31:16]));
            state_next.p1 = 34'($signed(startA[15:0]) * $signed(startB[15:0]));
            state_next.p2 = '0;
            state_next.p3 = '0;
        end else begin
            // Byte lanes, mixed form zero-extends first source
            uns = (startOp == GCD_OP_DOT_MIXED);
            state_next.p0 = lane_mul(startA[31:24], startB[31:24], uns);
            state_next.p1 = lane_mul(startA[23:16], startB[23:16], uns);
            state_next.p2 = lane_mul(startA[15:8], startB[15:8], uns);
            state_next.p3 = lane_mul(startA[7:0], startB[7:0], uns);
        end
        // Stage two: wide sum then clip or pass
        sum = 35'(state_reg.p0) + 35'(state_reg.p1) + 35'(state_reg.p2) + 35'(state_reg.p3);
        state_next.v2 = state_reg.v1;
        state_next.w2 = state_reg.w1;
        state_next.d2 = state_reg.d1;
        if (state_reg.op1 == GCD_OP_DOT_HALF && sum > 35'(signed'(GCD_SAT_MAX))) begin
            state_next.r2 = GCD_SAT_MAX;  // Clip high
        end else if (state_reg.op1 == GCD_OP_DOT_HALF && sum < -35'sh080000000) begin
            state_next.r2 = GCD_SAT_MIN;  // Clip low
        end else begin
            state_next.r2 = sum[31:0];    // Byte sums always fit exactly
        end
        // Stage three: writeback only when guarded true
        state_next.out.write = state_reg.v2 & state_reg.w2;
        state_next.out.dest  = state_reg.d2;
        state_next.out.data  = state_reg.r2;
    end

    // Pipeline registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dotWb = state_reg.out;
endmodule

// ### rtl/gcd_datapath.sv
// Guarded compare and dot product execution datapath
`timescale 1ns/10ps
module gcd_datapath (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  gcd_pkg::gcd_issue_t  issue,
    output gcd_pkg::gcd_wb_t     aluWb,
    output gcd_pkg::gcd_wb_t     dspWb
);
    import gcd_pkg::*;

    // Compare lane state
    typedef struct packed {
        gcd_wb_t out;
    } gcd_alu_state_t;

    gcd_alu_state_t state_reg;   // Registered compare result
    gcd_alu_state_t state_next;  // Next compare result
    logic           guardTrue;   // Effective guard
    logic           isDot;       // Dot product opcode
    gcd_wb_t        dotWb;       // Pipeline output

    // Effective guard: absent guard counts as true
    always_comb begin
        guardTrue = issue.guardUsed ? issue.guard[0] : 1'b1;
        isDot = issue.opcode == GCD_OP_DOT_HALF || issue.opcode == GCD_OP_DOT_BYTE ||
                issue.opcode == GCD_OP_DOT_MIXED;
    end

    // Compare lane, one-cycle result
    always_comb begin
        state_next = state_reg;
        state_next.out.write = 1'b0;
        state_next.out.dest  = issue.dest;
        state_next.out.data  = GCD_ZERO;
        if (issue.valid && issue.opcode == GCD_OP_CMP_REG) begin
            // Signed equality of both sources
            state_next.out.write = guardTrue;
            state_next.out.data  = {31'h0, ($signed(issue.firstSource) == $signed(issue.secondSource))};
        end else if (issue.valid && issue.opcode == GCD_OP_CMP_IMM) begin
            // Sign-extended modifier against source
            state_next.out.write = guardTrue;
            state_next.out.data  = {31'h0, ($signed(issue.firstSource) == 32'($signed(issue.modifier)))};
        end
    end

    // Compare result register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Dot product pipeline
    gcd_dot_pipe i_gcd_dot_pipe (
        .clk        (clk),
        .rst_n      (rst_n),
        .startValid (issue.valid & isDot),
        .startOp    (issue.opcode),
        .startA     (issue.firstSource),
        .startB     (issue.secondSource),
        .startWrite (guardTrue),
        .startDest  (issue.dest),
        .dotWb      (dotWb)
    );

    assign aluWb = state_reg.out;
    assign dspWb = dotWb;

    // Helper: signed reference sums for checking
    logic signed [34:0] refHalf;
    logic signed [34:0] refByte;
    always_comb begin
        refHalf = 35'($signed(issue.firstSource[31:16]) * $signed(issue.secondSource[31:16])) +
                  35'($signed(issue.firstSource[15:0]) * $signed(issue.secondSource[15:0]));
        refByte = 35'($signed(issue.firstSource[31:24]) * $signed(issue.secondSource[31:24])) +
                  35'($signed(issue.firstSource[23:16]) * $signed(issue.secondSource[23:16])) +
                  35'($signed(issue.firstSource[15:8]) * $signed(issue.secondSource[15:8])) +
                  35'($signed(issue.firstSource[7:0]) * $signed(issue.secondSource[7:0]));
    end

    cmp_reg_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_CMP_REG && !issue.guardUsed |=>
        aluWb.write && aluWb.data == {31'h0, $past(issue.firstSource == issue.secondSource)})
        else $error("register compare result wrong");
    cmp_imm_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_CMP_IMM && !issue.guardUsed |=>
        aluWb.data[0] == $past(issue.firstSource == 32'($signed(issue.modifier))))
        else $error("immediate compare result wrong");
    guard_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.guardUsed && !issue.guard[0] |=> !aluWb.write ##2 !dspWb.write)
        else $error("write despite false guard");
    no_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && isDot && !issue.guardUsed |-> ##3 dspWb.write)
        else $error("unguarded dot product not written");
    dot_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
        dspWb.write |-> $past(issue.valid && isDot, 3))
        else $error("dot product write without issue three cycles back");
    half_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_HALF && refHalf > 35'sh07FFFFFFF |-> ##3
        dspWb.data == GCD_SAT_MAX)
        else $error("halfword sum not clipped");
    half_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_HALF && refHalf <= 35'sh07FFFFFFF |-> ##3
        dspWb.data == $past(refHalf[31:0], 3))
        else $error("halfword sum wrong");
    byte_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_BYTE |-> ##3 dspWb.data == $past(refByte[31:0], 3))
        else $error("signed byte sum wrong");
    mixed_sign_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_MIXED && issue.secondSource == 32'hFFFFFFFF |-> ##3
        $signed(dspWb.data) == -$signed(32'($past(issue.firstSource[31:24], 3)) + 32'($past(issue.firstSource[23:16], 3))
        + 32'($past(issue.firstSource[15:8], 3)) + 32'($past(issue.firstSource[7:0], 3))))
        else $error("mixed byte sum wrong");
    byte_nosat_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_BYTE && issue.firstSource == 32'h80808080 &&
        issue.secondSource == 32'h80808080 |-> ##3 dspWb.data == 32'h00010000)
        else $error("byte sum saturated");

    cmp_seen_c: cover property (@(posedge clk) disable iff (!rst_n) aluWb.write && aluWb.data[0]);
    half_clip_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_HALF && refHalf > 35'sh07FFFFFFF);
    mixed_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.opcode == GCD_OP_DOT_MIXED ##3 dspWb.write);
    guard_off_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue.valid && issue.guardUsed && !issue.guard[0]);
endmodule

// ### bench/gcd_regfile_model.sv
// Register file model that takes the datapath writeback ports
`timescale 1ns/10ps
module gcd_regfile_model (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  gcd_pkg::gcd_wb_t  aluWb,
    input  gcd_pkg::gcd_wb_t  dspWb,
    output logic [31:0][31:0] fileReg
);
    import gcd_pkg::*;
    // Writes land on the edge that follows each pulse
    // The dot product result wins when both hit one index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fileReg <= '0;
        end else begin
            if (aluWb.write) begin
                fileReg[aluWb.dest] <= aluWb.data;
            end
            if (dspWb.write) begin
                fileReg[dspWb.dest] <= dspWb.data;
            end
        end
    end
endmodule

// ### bench/test_gcd_datapath.sv
// Self-checking testbench for the guarded compare and dot product datapath
`timescale 1ns/10ps
module test_gcd_datapath;
    import gcd_pkg::*;
    // One table row: operands, guard, expected write and data
    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] a;
        logic [31:0] b;
        logic [6:0]  m;
        logic        gu;
        logic        g;
        logic        wr;
        logic [31:0] d;
    } gcd_row_t;
    localparam gcd_row_t ROWS [20] = '{
        '{8'h25, 32'h3, 32'h4, 7'h00, 1'b0, 1'b0, 1'b1, 32'h0},
        '{8'h25, 32'h1000, 32'h1000, 7'h00, 1'b1, 1'b1, 1'b1, 32'h1},
        '{8'h25, 32'h80000000, 32'h80000000, 7'h00, 1'b0, 1'b0, 1'b1, 32'h1},
        '{8'h25, 32'h100, 32'h3, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0},
        '{8'h04, 32'h3, 32'h0, 7'h03, 1'b0, 1'b0, 1'b1, 32'h1},
        '{8'h04, 32'h3, 32'h0, 7'h04, 1'b0, 1'b0, 1'b1, 32'h0},
        '{8'h04, 32'hFFFFFFC0, 32'h0, 7'h40, 1'b0, 1'b0, 1'b1, 32'h1},
        '{8'h04, 32'h100, 32'h0, 7'h3F, 1'b1, 1'b1, 1'b1, 32'h0},
        '{8'h5D, 32'h00020003, 32'h00010002, 7'h00, 1'b0, 1'b0, 1'b1, 32'h8},
        '{8'h5D, 32'hFF9C0064, 32'h0064FF9C, 7'h00, 1'b1, 1'b1, 1'b1, 32'hFFFFB1E0},
        '{8'h5D, 32'h80008000, 32'h80008000, 7'h00, 1'b0, 1'b0, 1'b1, 32'h7FFFFFFF},
        '{8'h5D, 32'h80008000, 32'h80008000, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0},
        '{8'h5C, 32'h0AFB14F6, 32'h0A0A1414, 7'h00, 1'b0, 1'b0, 1'b1, 32'hFA},
        '{8'h5C, 32'h649C649C, 32'h9C649C64, 7'h00, 1'b1, 1'b1, 1'b1, 32'hFFFF63C0},
        '{8'h5C, 32'h80808080, 32'hFFFFFFFF, 7'h00, 1'b0, 1'b0, 1'b1, 32'h200},
        '{8'h5B, 32'h9C649C64, 32'h649C649C, 7'h00, 1'b0, 1'b0, 1'b1, 32'h2BC0},
        '{8'h5B, 32'hFFFFFFFF, 32'h80808080, 7'h00, 1'b0, 1'b0, 1'b1, 32'hFFFE0200},
        '{8'h5B, 32'h80808080, 32'hFFFFFFFF, 7'h00, 1'b0, 1'b0, 1'b1, 32'hFFFFFE00},
        '{8'h5C, 32'h80808080, 32'h80808080, 7'h00, 1'b1, 1'b1, 1'b1, 32'h00010000},
        '{8'h26, 32'h5, 32'h5, 7'h00, 1'b0, 1'b0, 1'b0, 32'h0}
    };
    logic             clk;         // Core clock
    logic             rst_n;       // Async reset, active low
    gcd_issue_t       issue;       // Issued operation
    gcd_wb_t          aluWb;       // Compare writeback
    gcd_wb_t          dspWb;       // Dot product writeback
    logic [31:0][31:0] fileReg;    // Model register file
    int               failCount;   // Mismatches
    int               compares;    // Comparisons made
    gcd_datapath i_gcd_datapath (.clk(clk), .rst_n(rst_n), .issue(issue), .aluWb(aluWb), .dspWb(dspWb));
    gcd_regfile_model i_gcd_regfile_model (.clk(clk), .rst_n(rst_n), .aluWb(aluWb), .dspWb(dspWb),
                                           .fileReg(fileReg));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Verdict and stop
    task automatic end_sim();
        $display("compares %0d failCount %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Present one operation just after an edge
    task automatic drive(input gcd_row_t r, input logic [4:0] dest);
        @(posedge clk);
        #1;
        issue = '{1'b1, r.op, r.a, r.b, r.m, r.gu, {31'h7FFFFFFF, r.g}, dest};
    endtask
    function automatic logic isDot(input logic [7:0] op);
        return op inside {GCD_OP_DOT_MIXED, GCD_OP_DOT_BYTE, GCD_OP_DOT_HALF};
    endfunction
    // Hang guard
    initial begin
        #20000;
        failCount++;
        end_sim();
    end
    // Main sequence
    initial begin
        gcd_wb_t seen;
        gcd_wb_t other;
        failCount = 0;
        compares = 0;
        rst_n = 1'b0;
        issue = '0;
        repeat (16) @(posedge clk);
        check("alu write in reset", 32'(aluWb.write), 32'h0);
        check("alu data in reset", aluWb.data, 32'h0);
        check("dsp write in reset", 32'(dspWb.write), 32'h0);
        check("dsp data in reset", dspWb.data, 32'h0);
        #1;
        rst_n = 1'b1;
        // Table rows, one op at a time, answer seen at the exact latency
        for (int i = 0; i < 20; i++) begin
            drive(ROWS[i], i[4:0]);
            @(posedge clk);
            #1;
            issue.valid = 1'b0;
            repeat (isDot(ROWS[i].op) ? GCD_DSP_LAT - 1 : GCD_ALU_LAT - 1) @(posedge clk);
            #1;
            seen = isDot(ROWS[i].op) ? dspWb : aluWb;
            other = isDot(ROWS[i].op) ? aluWb : dspWb;
            check("write", 32'(seen.write), 32'(ROWS[i].wr));
            check("other write", 32'(other.write), 32'h0);
            if (ROWS[i].wr) begin
                check("data", seen.data, ROWS[i].d);
                check("dest", 32'(seen.dest), i);
            end
        end
        // Back to back: half dot and immediate compare answer in one cycle
        drive(ROWS[8], 5'h1A);
        drive(ROWS[1], 5'h1B);
        drive(ROWS[6], 5'h1C);
        drive(ROWS[11], 5'h1D);
        drive(ROWS[15], 5'h1E);
        @(posedge clk);
        #1;
        issue.valid = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("file 1A", fileReg[26], 32'h8);
        check("file 1B", fileReg[27], 32'h1);
        check("file 1C", fileReg[28], 32'h1);
        check("file 1D", fileReg[29], 32'h0);
        check("file 1E", fileReg[30], 32'h2BC0);
        // Reset in mid flight drops the pending dot product
        drive(ROWS[12], 5'h1F);
        @(posedge clk);
        #1;
        issue.valid = 1'b0;
        rst_n = 1'b0;
        #1;
        check("dsp write after reset", 32'(dspWb.write), 32'h0);
        check("dsp data after reset", dspWb.data, 32'h0);
        // Release before the dropped result would have landed
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) begin
            @(posedge clk);
            #1;
            check("dsp write idle", 32'(dspWb.write), 32'h0);
        end
        check("file 1F", fileReg[31], 32'h0);
        // First compare right after release
        drive(ROWS[4], 5'h02);
        @(posedge clk);
        #1;
        issue.valid = 1'b0;
        check("alu write after release", 32'(aluWb.write), 32'h1);
        check("alu data after release", aluWb.data, 32'h1);
        end_sim();
    end
endmodule
